//--- src/ethc_regs.svh
/*
 * ethc_regs.svh: offsets, field positions, reset values and masks of
 * the main control register and its companion register map.
 * Assumes the including file uses the values as plain constants.
 */
`ifndef ETHC_REGS_SVH
`define ETHC_REGS_SVH

// ----------------------------------------------------------------
// banks and offsets
// ----------------------------------------------------------------
`define ETHC_BANK2 2'h2
`define ETHC_BANK3 2'h3
`define ETHC_OFF_MAIN 5'h1F
`define ETHC_OFF_STATUS 5'h1D
`define ETHC_OFF_PHY_INDEX 5'h14
`define ETHC_OFF_PHY_WR_LO 5'h16
`define ETHC_OFF_PHY_RD_LO 5'h18
`define ETHC_OFF_STATION 5'h00
`define ETHC_OFF_BIST_SEED 5'h06
`define ETHC_OFF_BIST_CTRL 5'h07
`define ETHC_OFF_BIST_SUM_LO 5'h08
`define ETHC_OFF_MGMT 5'h0A
`define ETHC_OFF_REVISION 5'h12
`define ETHC_OFF_CLK_OUT 5'h15
`define ETHC_OFF_FLOW 5'h17
`define ETHC_OFF_PAUSE_LO 5'h18

// ----------------------------------------------------------------
// storage indexes of the plain registers
// ----------------------------------------------------------------
`define ETHC_NREG 18
`define ETHC_IX_PHY_INDEX 5'h00
`define ETHC_IX_PHY_WR_LO 5'h01
`define ETHC_IX_PHY_RD_LO 5'h03
`define ETHC_IX_STATION 5'h05
`define ETHC_IX_BIST_SEED 5'h0B
`define ETHC_IX_BIST_CTRL 5'h0C
`define ETHC_IX_BIST_SUM_LO 5'h0D
`define ETHC_IX_FLOW 5'h0F
`define ETHC_IX_PAUSE_LO 5'h10
`define ETHC_IX_PAUSE_HI 5'h11

// ----------------------------------------------------------------
// fields, masks, reset values
// ----------------------------------------------------------------
`define ETHC_B_TX_RST 7
`define ETHC_B_RX_RST 6
`define ETHC_B_DMA_GO 5
`define ETHC_B_DMA_SUM 4
`define ETHC_B_TX_REQ 3
`define ETHC_B_RX_EN 2
`define ETHC_MAIN_RST 8'h00
`define ETHC_MASK_INDEX 8'h1F
`define ETHC_MASK_3BIT 8'h07
`define ETHC_MASK_FULL 8'hFF
`define ETHC_RST_PAUSE_HI 8'h10
`define ETHC_RST_ZERO 8'h00
`define ETHC_RST_CLK_OUT 3'h4

`endif

//--- src/ethc_pkg.sv
/*
 * ethc_pkg: types of the main control register block.
 * Assumes ethc_regs.svh holds the numeric constants.
 */
`default_nettype none
package ethc_pkg;
    // host register operations as decoded from the serial command
    typedef enum logic [1:0] {
        op_read = 2'b00,
        op_write = 2'b01,
        op_bit_set = 2'b10,
        op_bit_clr = 2'b11
    } ethc_op_t;

    typedef struct packed {
        logic valid;
        ethc_op_t op;
        logic [4:0] addr;
        logic [7:0] data;
    } ethc_cmd_t;

    // what an address lands on
    typedef enum logic [2:0] {
        kind_none = 3'b000,
        kind_plain = 3'b001,
        kind_main = 3'b010,
        kind_status = 3'b011,
        kind_rev = 3'b100,
        kind_clkout = 3'b101,
        kind_mgmt = 3'b110
    } ethc_kind_t;

    typedef struct packed {
        ethc_kind_t kind;
        logic [4:0] idx;
    } ethc_dec_t;

    typedef struct packed {
        logic busy;
        logic scan;
        logic nvalid;
    } ethc_mgmt_t;

    // configuration seen by the engines
    typedef struct packed {
        logic [4:0] phy_index;
        logic [15:0] phy_wdata;
        logic [47:0] station;
        logic [7:0] bist_seed;
        logic [7:0] bist_ctrl;
        logic [2:0] flow;
        logic [15:0] pause;
        logic [2:0] clk_out;
    } ethc_cfg_t;
endpackage : ethc_pkg
`default_nettype wire

//--- src/ethc_main_regs.sv
/*
 * ethc_main_regs: main control register and banked register map of
 * the Ethernet controller, reached by decoded serial commands.
 * Assumes the serial front end delivers one command per valid cycle
 * and that the engines answer with one-cycle done pulses.
 */
`include "ethc_regs.svh"
`default_nettype none

// Contract
// - transmit reset bit holds transmit logic reset
// - receive reset bit holds receive logic reset
// - dma busy bit reads one while running
// - sum select picks checksum over copy
// - transmit request reads one while sending
// - receive enable stores packets, else discards
// - bank select routes banked register accesses
// - revision register read-only, silicon dependent value
// - clock-out field loads 100 on power-on only
// - clock ready clears on power-on only
module ethc_main_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic por_n,
    input wire ethc_pkg::ethc_cmd_t cmd,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic tx_logic_rst,
    output logic rx_logic_rst,
    output logic dma_start,
    output logic dma_busy,
    output logic dma_sum_mode,
    input wire logic dma_done,
    output logic tx_start,
    output logic tx_request,
    input wire logic tx_done,
    input wire logic rx_pkt_ok,
    output logic rx_pkt_store,
    output logic [1:0] bank,
    input wire logic [4:0] revision,
    input wire logic osc_ready,
    output logic clock_ready,
    input wire ethc_pkg::ethc_mgmt_t mgmt,
    input wire logic phy_rd_load,
    input wire logic [15:0] phy_rd_data,
    input wire logic bist_sum_load,
    input wire logic [15:0] bist_sum,
    output ethc_pkg::ethc_cfg_t cfg
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // map bank and offset onto a register kind and storage index
    function automatic ethc_pkg::ethc_dec_t ethc_decode(
        input logic [1:0] bsel,
        input logic [4:0] off
    );
        ethc_pkg::ethc_dec_t d;
        d.kind = ethc_pkg::kind_none;
        d.idx = 5'h00;
        if (off == `ETHC_OFF_MAIN)
        begin
            d.kind = ethc_pkg::kind_main;
        end
        else if (off == `ETHC_OFF_STATUS)
        begin
            d.kind = ethc_pkg::kind_status;
        end
        else if (bsel == `ETHC_BANK2)
        begin
            if (off == `ETHC_OFF_PHY_INDEX)
            begin
                d.kind = ethc_pkg::kind_plain;
                d.idx = `ETHC_IX_PHY_INDEX;
            end
            else if (off >= `ETHC_OFF_PHY_WR_LO && off <= 5'h19)
            begin
                d.kind = ethc_pkg::kind_plain;
                d.idx = 5'(off - `ETHC_OFF_PHY_WR_LO + `ETHC_IX_PHY_WR_LO);
            end
        end
        else if (bsel == `ETHC_BANK3)
        begin
            if (off <= 5'h09)
            begin
                d.kind = ethc_pkg::kind_plain;
                d.idx = 5'(off + `ETHC_IX_STATION);
            end
            else if (off == `ETHC_OFF_MGMT)
            begin
                d.kind = ethc_pkg::kind_mgmt;
            end
            else if (off == `ETHC_OFF_REVISION)
            begin
                d.kind = ethc_pkg::kind_rev;
            end
            else if (off == `ETHC_OFF_CLK_OUT)
            begin
                d.kind = ethc_pkg::kind_clkout;
            end
            else if (off == `ETHC_OFF_FLOW)
            begin
                d.kind = ethc_pkg::kind_plain;
                d.idx = `ETHC_IX_FLOW;
            end
            else if (off == `ETHC_OFF_PAUSE_LO || off == 5'h19)
            begin
                d.kind = ethc_pkg::kind_plain;
                d.idx = 5'(off - `ETHC_OFF_PAUSE_LO + `ETHC_IX_PAUSE_LO);
            end
        end
        return d;
    endfunction : ethc_decode

    // apply a write, bit-set or bit-clear to an old value
    function automatic logic [7:0] ethc_apply(
        input ethc_pkg::ethc_op_t op,
        input logic [7:0] old,
        input logic [7:0] d
    );
        logic [7:0] r;
        r = old;
        unique case (op)
            ethc_pkg::op_write: r = d;
            ethc_pkg::op_bit_set: r = old | d;
            ethc_pkg::op_bit_clr: r = old & ~d;
            ethc_pkg::op_read: r = old;
        endcase
        return r;
    endfunction : ethc_apply

    // implemented bits of each plain register
    function automatic logic [7:0] ethc_mask(input logic [4:0] ix);
        logic [7:0] m;
        m = `ETHC_MASK_FULL;
        if (ix == `ETHC_IX_PHY_INDEX)
        begin
            m = `ETHC_MASK_INDEX;
        end
        else if (ix == `ETHC_IX_FLOW)
        begin
            m = `ETHC_MASK_3BIT;
        end
        return m;
    endfunction : ethc_mask

    // reset value of each plain register
    function automatic logic [7:0] ethc_rst_val(input logic [4:0] ix);
        logic [7:0] v;
        v = `ETHC_RST_ZERO;
        if (ix == `ETHC_IX_PAUSE_HI)
        begin
            v = `ETHC_RST_PAUSE_HI;
        end
        return v;
    endfunction : ethc_rst_val

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] main_r;
    logic [7:0] main_nxt;
    logic [7:0] regs_r [`ETHC_NREG];
    logic [7:0] regs_nxt [`ETHC_NREG];
    logic [2:0] clk_out_r;
    logic clk_rdy_r;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    logic dma_start_r;
    logic tx_start_r;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------

    // bank routing uses the live bank select field
    ethc_pkg::ethc_dec_t dec;
    logic is_wr;
    logic is_rd;
    logic main_wr;
    logic plain_wr;
    logic clk_wr;
    logic [7:0] main_sw;
    logic [7:0] plain_sw;
    logic [7:0] clk_sw;
    logic dma_set;
    logic tx_set;
    assign dec = ethc_decode(main_r[1:0], cmd.addr);
    assign is_wr = cmd.valid && cmd.op != ethc_pkg::op_read;
    assign is_rd = cmd.valid && cmd.op == ethc_pkg::op_read;
    assign main_wr = is_wr && dec.kind == ethc_pkg::kind_main;
    assign plain_wr = is_wr && dec.kind == ethc_pkg::kind_plain;
    assign clk_wr = is_wr && dec.kind == ethc_pkg::kind_clkout;
    assign main_sw = ethc_apply(cmd.op, main_r, cmd.data);
    assign plain_sw = ethc_apply(cmd.op, regs_r[dec.idx], cmd.data);
    assign clk_sw = ethc_apply(cmd.op, {5'h00, clk_out_r}, cmd.data);

    // a host write that raises a start bit launches the engine
    assign dma_set = main_wr && main_sw[`ETHC_B_DMA_GO] && !main_r[`ETHC_B_DMA_GO];
    assign tx_set = main_wr && main_sw[`ETHC_B_TX_REQ] && !main_r[`ETHC_B_TX_REQ];

    // ------------------------------------------------------------
    // main control next value
    // ------------------------------------------------------------

    // busy bits drop on the engine's done pulse; a new start wins
    always_comb
    begin
        main_nxt = main_wr ? main_sw : main_r;
        main_nxt[`ETHC_B_DMA_GO] = dma_set || (main_nxt[`ETHC_B_DMA_GO] && !dma_done);
        main_nxt[`ETHC_B_TX_REQ] = tx_set || (main_nxt[`ETHC_B_TX_REQ] && !tx_done);
    end

    // main control register, cleared by the general reset nrst only, not by por_n
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            main_r <= `ETHC_MAIN_RST;
            dma_start_r <= 1'b0;
            tx_start_r <= 1'b0;
        end
        else
        begin
            main_r <= main_nxt;
            dma_start_r <= dma_set;
            tx_start_r <= tx_set;
        end
    end

    // ------------------------------------------------------------
    // plain registers
    // ------------------------------------------------------------

    // host writes through the mask, engines load result registers
    always_comb
    begin
        for (int i = 0; i < `ETHC_NREG; i++)
        begin
            regs_nxt[i] = regs_r[i];
        end
        if (plain_wr)
        begin
            regs_nxt[dec.idx] = plain_sw & ethc_mask(dec.idx);
        end
        if (phy_rd_load)
        begin
            regs_nxt[`ETHC_IX_PHY_RD_LO] = phy_rd_data[7:0];
            regs_nxt[`ETHC_IX_PHY_RD_LO + 5'h01] = phy_rd_data[15:8];
        end
        if (bist_sum_load)
        begin
            regs_nxt[`ETHC_IX_BIST_SUM_LO] = bist_sum[7:0];
            regs_nxt[`ETHC_IX_BIST_SUM_LO + 5'h01] = bist_sum[15:8];
        end
    end

    // plain register storage
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < `ETHC_NREG; i++)
            begin
                regs_r[i] <= ethc_rst_val(5'(i));
            end
        end
        else
        begin
            regs_r <= regs_nxt;
        end
    end

    // ------------------------------------------------------------
    // power-on only state
    // ------------------------------------------------------------

    // clock-out select and clock ready survive all but power-on
    always_ff @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            clk_out_r <= `ETHC_RST_CLK_OUT;
            clk_rdy_r <= 1'b0;
        end
        else
        begin
            if (clk_wr)
            begin
                clk_out_r <= clk_sw[2:0];
            end
            if (osc_ready)
            begin
                clk_rdy_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // revision comes straight from the silicon pins, never stored
    logic [7:0] rd_mux;
    always_comb
    begin
        unique case (dec.kind)
            ethc_pkg::kind_main: rd_mux = main_r;
            ethc_pkg::kind_plain: rd_mux = regs_r[dec.idx];
            ethc_pkg::kind_status: rd_mux = {7'h00, clk_rdy_r};
            ethc_pkg::kind_rev: rd_mux = {3'h0, revision};
            ethc_pkg::kind_clkout: rd_mux = {5'h00, clk_out_r};
            ethc_pkg::kind_mgmt: rd_mux = {5'h00, mgmt.nvalid, mgmt.scan, mgmt.busy};
            default: rd_mux = 8'h00;
        endcase
    end

    // read answer one cycle after the command
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= is_rd;
            if (is_rd)
            begin
                rd_data_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign tx_logic_rst = main_r[`ETHC_B_TX_RST];
    assign rx_logic_rst = main_r[`ETHC_B_RX_RST];
    assign dma_start = dma_start_r;
    assign dma_busy = main_r[`ETHC_B_DMA_GO];
    assign dma_sum_mode = main_r[`ETHC_B_DMA_SUM];
    assign tx_start = tx_start_r;
    assign tx_request = main_r[`ETHC_B_TX_REQ];
    assign bank = main_r[1:0];
    assign clock_ready = clk_rdy_r;

    // packets are kept only when receive is on and out of reset
    assign rx_pkt_store = rx_pkt_ok && main_r[`ETHC_B_RX_EN] && !main_r[`ETHC_B_RX_RST];

    // configuration gathered for the engines
    assign cfg.phy_index = regs_r[`ETHC_IX_PHY_INDEX][4:0];
    assign cfg.phy_wdata = {regs_r[`ETHC_IX_PHY_WR_LO + 5'h01], regs_r[`ETHC_IX_PHY_WR_LO]};
    assign cfg.station = {regs_r[9], regs_r[10], regs_r[7], regs_r[8], regs_r[5], regs_r[6]};
    assign cfg.bist_seed = regs_r[`ETHC_IX_BIST_SEED];
    assign cfg.bist_ctrl = regs_r[`ETHC_IX_BIST_CTRL];
    assign cfg.flow = regs_r[`ETHC_IX_FLOW][2:0];
    assign cfg.pause = {regs_r[`ETHC_IX_PAUSE_HI], regs_r[`ETHC_IX_PAUSE_LO]};
    assign cfg.clk_out = clk_out_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    tx_reset_hold_a: assert property (
        main_wr && cmd.op == ethc_pkg::op_write |=> tx_logic_rst == $past(cmd.data[7])
    ) else $error("transmit reset does not follow write");

    rx_reset_set_a: assert property (
        main_wr && cmd.data[6] && cmd.op inside {ethc_pkg::op_write, ethc_pkg::op_bit_set} |=> rx_logic_rst
    ) else $error("receive reset not set by host");

    dma_busy_span_a: assert property (
        dma_start |-> dma_busy
    ) else $error("dma start without busy");

    dma_idle_a: assert property (
        dma_busy && dma_done && !main_wr |=> !dma_busy
    ) else $error("dma busy stays after done");

    dma_mode_a: assert property (
        dma_start && !$past(main_wr && main_sw[4]) |-> !dma_sum_mode
    ) else $error("dma mode differs from select");

    tx_idle_a: assert property (
        tx_request && tx_done && !main_wr |=> !tx_request && !tx_start
    ) else $error("transmit request stays after done");

    rx_discard_a: assert property (
        rx_pkt_ok && !main_r[2] |-> !rx_pkt_store
    ) else $error("packet stored while receive off");

    bank_route_a: assert property (
        is_rd && main_r[1:0] == `ETHC_BANK3 && cmd.addr == `ETHC_OFF_STATION
        |=> rd_valid && rd_data == cfg.station[15:8]
    ) else $error("bank three station byte misrouted");

    rev_read_a: assert property (
        is_rd && dec.kind == ethc_pkg::kind_rev |=> rd_data == {3'h0, $past(revision)}
    ) else $error("revision read mismatch");

    clk_ready_a: assert property (
        osc_ready |=> clock_ready
    ) else $error("clock ready not set");

endmodule : ethc_main_regs
`default_nettype wire

//--- tb/ethc_host_model.sv
/*
 * ethc_host_model: host side of the register port, one decoded command at a time.
 * Assumes a free-running sys_clk and the design's registered read answer.
 */
`default_nettype none
module ethc_host_model (
    input wire logic sys_clk,
    output ethc_pkg::ethc_cmd_t cmd,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // command driver
    // ------------------------------------------------------------
    // idle at time zero
    initial cmd = '0;

    // request held one cycle; when released the address and data fields show the inverse so stale values never pass
    task automatic send(input ethc_pkg::ethc_op_t op, input logic [4:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        cmd <= '{valid: 1'b1, op: op, addr: addr, data: data};
        @(posedge sys_clk);
        cmd <= '{valid: 1'b0, op: op, addr: ~addr, data: ~data};
        #1; // return once the taken write has landed in the registers
    endtask : send

    // read: the answer must be flagged exactly one cycle after the taking edge
    task automatic rd_reg(input logic [4:0] addr, output logic [7:0] data, output logic ok);
        send(ethc_pkg::op_read, addr, 8'h00);
        @(posedge sys_clk);
        ok = (rd_valid === 1'b1);
        data = rd_data;
    endtask : rd_reg

    // updates of single control bits use set and clear, so reserved bits are never rewritten
    task automatic set_bits(input logic [4:0] addr, input logic [7:0] mask);
        send(ethc_pkg::op_bit_set, addr, mask);
    endtask : set_bits

    task automatic clr_bits(input logic [4:0] addr, input logic [7:0] mask);
        send(ethc_pkg::op_bit_clr, addr, mask);
    endtask : clr_bits
endmodule : ethc_host_model
`default_nettype wire

//--- tb/tb_top.sv
/*
 * tb_top: self-checking bench of the main control register block.
 * Assumes ethc_regs.svh on the include path and the host model beside it.
 */
`include "ethc_regs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [1:0] bank;
        logic [4:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } ethc_row_t;

    logic sys_clk = 1'b0, nrst = 1'b0, por_n = 1'b0;
    logic dma_done = 1'b0, tx_done = 1'b0, rx_pkt_ok = 1'b0, osc_ready = 1'b0;
    logic phy_rd_load = 1'b0, bist_sum_load = 1'b0;
    logic [15:0] phy_rd_data = 16'h0000, bist_sum = 16'h0000;
    logic [4:0] revision = 5'h0B;
    ethc_pkg::ethc_mgmt_t mgmt = 3'h5;
    ethc_pkg::ethc_cmd_t cmd;
    ethc_pkg::ethc_cfg_t cfg;
    logic [7:0] rd_data;
    logic [1:0] bank;
    logic rd_valid, tx_logic_rst, rx_logic_rst, dma_start, dma_busy, dma_sum_mode;
    logic tx_start, tx_request, rx_pkt_store, clock_ready;
    int n_fail = 0, num_checks = 0, cycles = 0;
    ethc_row_t rows [8];

    // ------------------------------------------------------------
    // clock, instances
    // ------------------------------------------------------------
    always #2 sys_clk = ~sys_clk;

    ethc_main_regs uut (.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n), .cmd(cmd), .rd_data(rd_data),
        .rd_valid(rd_valid), .tx_logic_rst(tx_logic_rst), .rx_logic_rst(rx_logic_rst), .dma_start(dma_start),
        .dma_busy(dma_busy), .dma_sum_mode(dma_sum_mode), .dma_done(dma_done), .tx_start(tx_start),
        .tx_request(tx_request), .tx_done(tx_done), .rx_pkt_ok(rx_pkt_ok), .rx_pkt_store(rx_pkt_store),
        .bank(bank), .revision(revision), .osc_ready(osc_ready), .clock_ready(clock_ready), .mgmt(mgmt),
        .phy_rd_load(phy_rd_load), .phy_rd_data(phy_rd_data), .bist_sum_load(bist_sum_load),
        .bist_sum(bist_sum), .cfg(cfg));

    ethc_host_model host (.sys_clk(sys_clk), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk

    // read one register and compare, the answer flag included
    task automatic rd_chk(input logic [4:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd_reg(addr, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask : rd_chk

    task automatic wr(input logic [4:0] addr, input logic [7:0] d);
        host.send(ethc_pkg::op_write, addr, d);
    endtask : wr

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // hang guard: the whole run needs well under this many cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = '{2'h3, 5'h00, 8'hAA, 8'hAA};
        rows[1] = '{2'h3, 5'h12, 8'hFF, 8'h0B};
        rows[2] = '{2'h2, 5'h14, 8'hFF, 8'h1F};
        rows[3] = '{2'h3, 5'h17, 8'hFF, 8'h07};
        rows[4] = '{2'h3, 5'h19, 8'h5A, 8'h5A};
        rows[5] = '{2'h0, 5'h05, 8'h77, 8'h00};
        rows[6] = '{2'h3, 5'h0A, 8'hFF, 8'h05};
        rows[7] = '{2'h1, 5'h1D, 8'hFF, 8'h00};
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        // power-on values
        rd_chk(`ETHC_OFF_MAIN, `ETHC_MAIN_RST);
        rd_chk(`ETHC_OFF_STATUS, 8'h00);
        wr(`ETHC_OFF_MAIN, 8'h03);
        rd_chk(`ETHC_OFF_CLK_OUT, {5'h00, `ETHC_RST_CLK_OUT});
        rd_chk(5'h19, `ETHC_RST_PAUSE_HI);
        $display("test reset values done");
        // banked map: select, write, read back
        foreach (rows[i])
        begin
            wr(`ETHC_OFF_MAIN, {6'h00, rows[i].bank});
            chk({6'h00, bank}, {6'h00, rows[i].bank});
            wr(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp);
        end
        chk(cfg.station[15:8], 8'hAA);
        chk({5'h00, cfg.flow}, 8'h07);
        chk(cfg.pause[15:8], 8'h5A);
        chk({3'h0, cfg.phy_index}, 8'h1F);
        $display("test register map done");
        // engine readback loads
        wr(`ETHC_OFF_MAIN, 8'h02);
        @(posedge sys_clk);
        phy_rd_load <= 1'b1;
        phy_rd_data <= 16'hBEEF;
        @(posedge sys_clk);
        phy_rd_load <= 1'b0;
        rd_chk(5'h18, 8'hEF);
        rd_chk(5'h19, 8'hBE);
        wr(`ETHC_OFF_MAIN, 8'h03);
        @(posedge sys_clk);
        bist_sum_load <= 1'b1;
        bist_sum <= 16'h1234;
        @(posedge sys_clk);
        bist_sum_load <= 1'b0;
        rd_chk(5'h08, 8'h34);
        rd_chk(5'h09, 8'h12);
        $display("test readback loads done");
        // dma in checksum then copy mode
        for (int m = 1; m >= 0; m--)
        begin
            wr(`ETHC_OFF_MAIN, {2'b00, 1'b1, m[0], 4'h0});
            @(posedge sys_clk);
            chk({5'h00, dma_start, dma_busy, dma_sum_mode}, {5'h00, 2'b11, m[0]});
            @(posedge sys_clk);
            chk({6'h00, dma_start, dma_busy}, 8'h01);
            dma_done <= 1'b1;
            @(posedge sys_clk);
            dma_done <= 1'b0;
            chk({7'h00, dma_busy}, 8'h01);
            @(posedge sys_clk);
            chk({7'h00, dma_busy}, 8'h00);
        end
        rd_chk(`ETHC_OFF_MAIN, 8'h00);
        $display("test dma done");
        // transmit request
        host.set_bits(`ETHC_OFF_MAIN, 8'h08);
        @(posedge sys_clk);
        chk({6'h00, tx_start, tx_request}, 8'h03);
        rd_chk(`ETHC_OFF_MAIN, 8'h08);
        @(posedge sys_clk);
        tx_done <= 1'b1;
        @(posedge sys_clk);
        tx_done <= 1'b0;
        @(posedge sys_clk);
        chk({7'h00, tx_request}, 8'h00);
        $display("test transmit done");
        // logic resets and receive enable
        wr(`ETHC_OFF_MAIN, 8'hC0);
        chk({6'h00, tx_logic_rst, rx_logic_rst}, 8'h03);
        host.set_bits(`ETHC_OFF_MAIN, 8'h04);
        rd_chk(`ETHC_OFF_MAIN, 8'hC4);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 1)
                host.clr_bits(`ETHC_OFF_MAIN, 8'h40);
            if (k == 2)
                host.clr_bits(`ETHC_OFF_MAIN, 8'h04);
            @(posedge sys_clk);
            rx_pkt_ok <= 1'b1;
            #1;
            chk({7'h00, rx_pkt_store}, {7'h00, k == 1});
            @(posedge sys_clk);
            rx_pkt_ok <= 1'b0;
        end
        host.clr_bits(`ETHC_OFF_MAIN, 8'h80);
        chk({6'h00, tx_logic_rst, rx_logic_rst}, 8'h00);
        $display("test receive and logic resets done");
        // general reset keeps clock-out and clock ready; power-on reset reloads clock-out to 100 and clears clock ready
        wr(`ETHC_OFF_MAIN, 8'h03);
        wr(`ETHC_OFF_CLK_OUT, 8'h02);
        osc_ready <= 1'b1;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_chk(`ETHC_OFF_MAIN, 8'h00);
        wr(`ETHC_OFF_MAIN, 8'h03);
        rd_chk(`ETHC_OFF_CLK_OUT, 8'h02);
        rd_chk(`ETHC_OFF_STATUS, 8'h01);
        rd_chk(5'h19, `ETHC_RST_PAUSE_HI);
        osc_ready <= 1'b0;
        nrst <= 1'b0;
        por_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        wr(`ETHC_OFF_MAIN, 8'h03);
        rd_chk(`ETHC_OFF_CLK_OUT, 8'h04);
        rd_chk(`ETHC_OFF_STATUS, 8'h00);
        chk({7'h00, clock_ready}, 8'h00);
        $display("test reset kinds done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
